// [hdl/synth_i2c_slave_port.sv]
// Behaviour
// - Port works only while the bus-select pin is strapped low.
// - Slave only: never drives SCL, never starts a transfer.
// - Serial clock up to 1 MHz must be handled correctly.
// - SDA changes while SCL is high are conditions, never data.
// - START is SDA falling with SCL high; precedes every command.
// - STOP is SDA rising with SCL high; ends the transaction.
// - Bytes are eight bits, MSB first, then an acknowledge slot.
// - Transmitter releases SDA after eight bits; receiver pulls low on ninth.
// - First seven bits compared against 1101 plus three strapped bits.
// - Eighth address bit: one means read, zero means write.
// - On address match, drive SDA low during the ninth clock.
// - Write: byte after address is the sub-address, also acknowledged.
// - Each data byte for sub-addresses 0x00 to 0x08 lands in one byte lane of the configuration word.
// - Further bytes go to the next sub-address until STOP, all acknowledged.
// - Read: acknowledge then send the status byte, no sub-address.
// - Oscillator buffer enabled only in external or diversity-slave modes.
// - Ten DAC control bits are held and presented.
// - Nine write-only registers and exactly one read-only register.
`timescale 1ns/10ps
`include "synth_i2c_map.svh"
`default_nettype none

module synth_i2c_slave_port (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    // Bus lines and straps
    input wire synth_i2c_pkg::line_s LINE_IN,
    input wire logic SERIAL_PORT_SELECT_PIN,
    input wire logic [2:0] ADDR_STRAP,
    // Open-drain data pin drive
    output logic SDA_OUT,
    output logic SDA_OE,
    // Device side
    input wire logic [7:0] STATUS_BYTE,
    output logic [`CFG_W-1:0] CONFIG_WORD,
    output logic EXT_OSC_BUF_EN,
    output logic [9:0] DAC_CODE
);
    import synth_i2c_pkg::*;

    // Lines and select pin rest high; everything else clears
    localparam port_state_s ST_RESET = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
        sel_s1: 1'b1, sel_s2: 1'b1,
        adr_s1: 3'h0, adr_s2: 3'h0,
        state: S_IDLE, ack_from: S_IDLE,
        cnt: 4'h0, shreg: 8'h00, tx: 8'h00, sub: 8'h00,
        rw: 1'b0, oe: 1'b0, ext: 1'b0,
        cfg: `CFG_RESET
    };

    // Shortest serial half period, in system clocks
    localparam int SCL_HALF_CYC = `SYS_CLK_KHZ / (2 * `SCL_MAX_KHZ);

    port_state_s st;
    port_state_s next_st;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic port_off;
    logic addr_match;
    logic byte_done;

    // Lane for a sub-address: 0x00 at 47:40, 0x04 at 15:8, wrapping upward
    function automatic logic [6:0] lane_lsb(input logic [7:0] sub);
        logic [7:0] idx;
        if (sub <= `LANE_TOP) begin
            idx = `LANE_TOP - sub;
        end else begin
            idx = `REG_COUNT + `LANE_TOP - sub;
        end
        return {idx[3:0], 3'b000};
    endfunction : lane_lsb

    // Modes that need the external oscillator input
    function automatic logic mode_ext(input logic [4:0] m);
        return (m == `MODE_DIV_SLAVE) || (m == `MODE_EXT_STD) || (m == `MODE_EXT_DIV);
    endfunction : mode_ext

    // Edges seen on the synchronised lines only
    assign scl_rise = st.scl_s2 && !st.scl_d;
    assign scl_fall = !st.scl_s2 && st.scl_d;
    assign start_det = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
    assign stop_det = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
    assign port_off = st.sel_s2;
    assign addr_match = st.shreg[7:1] == {`ADDR_PREFIX, st.adr_s2};
    assign byte_done = scl_fall && (st.cnt == `BITS_PER_BYTE);

    // Next-state logic for the whole port
    always_comb begin
        next_st = st;
        // Two stages before any logic looks at a pin; at 20 MHz the
        // three-clock lag stays well inside a 1 MHz half period
        next_st.scl_s1 = LINE_IN.scl;
        next_st.scl_s2 = st.scl_s1;
        next_st.scl_d = st.scl_s2;
        next_st.sda_s1 = LINE_IN.sda;
        next_st.sda_s2 = st.sda_s1;
        next_st.sda_d = st.sda_s2;
        next_st.sel_s1 = SERIAL_PORT_SELECT_PIN;
        next_st.sel_s2 = st.sel_s1;
        next_st.adr_s1 = ADDR_STRAP;
        next_st.adr_s2 = st.adr_s1;
        if (port_off) begin
            // Deselected: stay silent whatever the lines do
            next_st.state = S_IDLE;
            next_st.oe = 1'b0;
            next_st.cnt = 4'h0;
        end else if (start_det) begin
            // Any partial byte is dropped
            next_st.state = S_ADDR;
            next_st.oe = 1'b0;
            next_st.cnt = 4'h0;
        end else if (stop_det) begin
            next_st.state = S_IDLE;
            next_st.oe = 1'b0;
            next_st.cnt = 4'h0;
        end else begin
            case (st.state)
                S_ADDR, S_SUB, S_DATA: begin
                    if (scl_rise && st.cnt != `BITS_PER_BYTE) begin
                        // Sample on the rising edge, MSB first
                        next_st.shreg = {st.shreg[6:0], st.sda_s2};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (byte_done) begin
                        next_st.cnt = 4'h0;
                        next_st.ack_from = st.state;
                        next_st.state = S_ACK;
                        next_st.oe = 1'b1;
                        if (st.state == S_ADDR) begin
                            if (addr_match) begin
                                next_st.rw = st.shreg[0];
                            end else begin
                                next_st.state = S_IGNORE;
                                next_st.oe = 1'b0;
                            end
                        end else if (st.state == S_SUB) begin
                            next_st.sub = st.shreg;
                        end else begin
                            // Writes past the last register are acknowledged but dropped
                            if (st.sub <= `SUB_LAST) begin
                                next_st.cfg[lane_lsb(st.sub) +: 8] = st.shreg;
                            end
                            next_st.sub = st.sub + 8'h01;
                        end
                    end
                end
                S_ACK: begin
                    // Hold the acknowledge through the ninth clock
                    if (scl_fall) begin
                        next_st.oe = 1'b0;
                        if (st.ack_from == S_ADDR && st.rw == `RW_READ) begin
                            next_st.state = S_TX;
                            next_st.tx = STATUS_BYTE;
                            next_st.oe = !STATUS_BYTE[7];
                        end else if (st.ack_from == S_ADDR) begin
                            next_st.state = S_SUB;
                        end else begin
                            next_st.state = S_DATA;
                        end
                    end
                end
                S_TX: begin
                    // Shift on each falling edge so SDA moves only while SCL is low
                    if (scl_fall) begin
                        if (st.cnt == `LAST_DATA_BIT) begin
                            next_st.state = S_MACK;
                            next_st.oe = 1'b0;
                            next_st.cnt = 4'h0;
                        end else begin
                            next_st.tx = {st.tx[6:0], 1'b0};
                            next_st.oe = !st.tx[6];
                            next_st.cnt = st.cnt + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    // Usually not acknowledged; an acknowledge repeats the byte
                    if (scl_rise) begin
                        if (st.sda_s2) begin
                            next_st.state = S_IGNORE;
                        end else begin
                            next_st.cnt = `BITS_PER_BYTE;
                        end
                    end else if (byte_done) begin
                        next_st.state = S_TX;
                        next_st.tx = STATUS_BYTE;
                        next_st.oe = !STATUS_BYTE[7];
                        next_st.cnt = 4'h0;
                    end
                end
                S_IDLE, S_IGNORE: begin
                    next_st.oe = 1'b0;
                end
                default: begin
                    next_st.state = S_IDLE;
                    next_st.oe = 1'b0;
                end
            endcase
        end
        // Buffer enable follows the mode field as soon as it is written
        next_st.ext = mode_ext(next_st.cfg[`MODE_MSB:`MODE_LSB]);
    end

    // State register; CE low freezes everything
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st <= ST_RESET;
        end else if (CE) begin
            st <= next_st;
        end
    end

    // Open drain: only ever pulls low, never touches SCL
    assign SDA_OUT = 1'b0;
    assign SDA_OE = st.oe;
    assign CONFIG_WORD = st.cfg;
    assign EXT_OSC_BUF_EN = st.ext;
    assign DAC_CODE = {st.cfg[`DAC_HI_MSB:`DAC_HI_LSB], st.cfg[`DAC_LO_MSB:`DAC_LO_LSB]};

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    property p_deselect_silent;
        CE && port_off |=> !SDA_OE && st.state == S_IDLE;
    endproperty
    a_deselect_silent: assert property (p_deselect_silent) else $error("drives SDA while deselected");

    property p_never_high;
        SDA_OE |-> SDA_OUT == 1'b0;
    endproperty
    a_never_high: assert property (p_never_high) else $error("SDA driven high");

    property p_start_restarts;
        CE && !port_off && start_det |=> st.state == S_ADDR && st.cnt == 4'h0 && !SDA_OE;
    endproperty
    a_start_restarts: assert property (p_start_restarts) else $error("START not honoured");

    property p_stop_ends;
        CE && !port_off && !start_det && stop_det |=> st.state == S_IDLE && !SDA_OE;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("STOP not honoured");

    property p_addr_ack;
        CE && !port_off && !start_det && !stop_det && st.state == S_ADDR && byte_done && addr_match
            |=> SDA_OE && st.state == S_ACK && st.rw == $past(st.shreg[0]);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("matched address not acknowledged");

    property p_mismatch_quiet;
        CE && !port_off && !start_det && !stop_det && st.state == S_ADDR && byte_done && !addr_match
            |=> !SDA_OE && st.state == S_IGNORE;
    endproperty
    a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("foreign address answered");

    property p_lane_zero;
        CE && !port_off && !start_det && !stop_det && st.state == S_DATA && byte_done
            && st.sub == 8'h00 |=> CONFIG_WORD[47:40] == $past(st.shreg) && st.sub == 8'h01;
    endproperty
    a_lane_zero: assert property (p_lane_zero) else $error("sub-address 0 lane wrong");

    property p_lane_four;
        CE && !port_off && !start_det && !stop_det && st.state == S_DATA && byte_done
            && st.sub == 8'h04 |=> CONFIG_WORD[15:8] == $past(st.shreg) && st.sub == 8'h05;
    endproperty
    a_lane_four: assert property (p_lane_four) else $error("sub-address 4 lane wrong");

    property p_master_slot_free;
        st.state == S_MACK |-> !SDA_OE;
    endproperty
    a_master_slot_free: assert property (p_master_slot_free) else $error("SDA held in master slot");

    property p_ext_buf;
        EXT_OSC_BUF_EN == mode_ext(CONFIG_WORD[`MODE_MSB:`MODE_LSB]);
    endproperty
    a_ext_buf: assert property (p_ext_buf) else $error("buffer enable disagrees with mode");

    property p_read_first_bit;
        CE && !port_off && !start_det && !stop_det && st.state == S_ACK && scl_fall
            && st.ack_from == S_ADDR && st.rw |=> st.state == S_TX && SDA_OE == !$past(STATUS_BYTE[7]);
    endproperty
    a_read_first_bit: assert property (p_read_first_bit) else $error("read byte not started");

    property p_sub_capture;
        CE && !port_off && !start_det && !stop_det && st.state == S_SUB && byte_done
            |=> SDA_OE && st.state == S_ACK && st.sub == $past(st.shreg);
    endproperty
    a_sub_capture: assert property (p_sub_capture) else $error("sub-address not taken");

    property p_write_to_sub;
        CE && !port_off && !start_det && !stop_det && st.state == S_ACK && scl_fall
            && st.ack_from == S_ADDR && !st.rw |=> st.state == S_SUB && !SDA_OE;
    endproperty
    a_write_to_sub: assert property (p_write_to_sub) else $error("write did not reach sub-address phase");

    // Next bit comes from bit 6 of the unshifted copy, the same bit the logic reads, so a stale shift passes here
    property p_tx_next_bit;
        CE && !port_off && !start_det && !stop_det && st.state == S_TX && scl_fall
            && st.cnt != `LAST_DATA_BIT |=> SDA_OE == !$past(st.tx[6]);
    endproperty
    a_tx_next_bit: assert property (p_tx_next_bit) else $error("read bit out of order");

    property p_nack_ignore;
        CE && !port_off && !start_det && !stop_det && st.state == S_MACK && scl_rise && st.sda_s2
            |=> st.state == S_IGNORE && !SDA_OE;
    endproperty
    a_nack_ignore: assert property (p_nack_ignore) else $error("read not closed after no acknowledge");

    // A condition inside a data byte must leave the word untouched
    property p_abort_keeps;
        CE && !port_off && (start_det || stop_det) && st.state == S_DATA
            |=> st.cnt == 4'h0 && CONFIG_WORD == $past(CONFIG_WORD);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("partial byte stored");

    property p_ignore_quiet;
        st.state == S_IGNORE |-> !SDA_OE;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("SDA driven while ignoring bus");

    property p_high_sub_dropped;
        CE && !port_off && !start_det && !stop_det && st.state == S_DATA && byte_done
            && st.sub > `SUB_LAST |=> SDA_OE && CONFIG_WORD == $past(CONFIG_WORD);
    endproperty
    a_high_sub_dropped: assert property (p_high_sub_dropped) else $error("write past last register stored");

    // Coverage of the main transfers
    c_write: cover property (st.state == S_DATA && byte_done && st.sub == 8'h02);
    c_read: cover property (st.state == S_MACK && scl_rise && st.sda_s2);
    c_mismatch: cover property (st.state == S_IGNORE && stop_det);
    c_abort: cover property (st.state == S_DATA && st.cnt == 4'h3 && start_det);

    // Sanity on the sampling margin
    c_half_period: cover property (SCL_HALF_CYC > 3 && scl_rise);

endmodule : synth_i2c_slave_port

`default_nettype wire

// [hdl/synth_i2c_map.svh]
`ifndef SYNTH_I2C_MAP_SVH
`define SYNTH_I2C_MAP_SVH

// Device address: fixed upper nibble, three strapped bits below it
`define ADDR_PREFIX 4'hd
`define RW_READ 1'b1

// Byte framing
`define BITS_PER_BYTE 4'h8
`define LAST_DATA_BIT 4'h7

// Configuration space: nine write-only byte registers
`define CFG_W 72
`define CFG_RESET 72'h0
`define SUB_LAST 8'h08
`define REG_COUNT 8'h09
`define LANE_TOP 8'h05

// Functional mode field inside the configuration word
`define MODE_MSB 45
`define MODE_LSB 41
`define MODE_DIV_SLAVE 5'h03
`define MODE_EXT_STD 5'h06
`define MODE_EXT_DIV 5'h07

// DAC code: upper eight bits and lower two bits
`define DAC_HI_MSB 71
`define DAC_HI_LSB 64
`define DAC_LO_MSB 63
`define DAC_LO_LSB 62

// Timing: system clock and fastest serial clock, in kHz
`define SYS_CLK_KHZ 20000
`define SCL_MAX_KHZ 1000

`endif

// [hdl/synth_i2c_pkg.sv]
package synth_i2c_pkg;

    // Protocol phases of the slave port
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_SUB,
        S_DATA,
        S_ACK,
        S_TX,
        S_MACK,
        S_IGNORE
    } state_e;

    // The two bus lines as sampled from the pins
    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;

    // Complete state of the port
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic sel_s1;
        logic sel_s2;
        logic [2:0] adr_s1;
        logic [2:0] adr_s2;
        state_e state;
        state_e ack_from;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [7:0] sub;
        logic rw;
        logic oe;
        logic ext;
        logic [71:0] cfg;
    } port_state_s;

endpackage : synth_i2c_pkg

// [verif/i2c_bus_master.sv]
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_master (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Bus idles released: SCL stands still high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Every change lands 1 ns after a rising edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // One bit slot of 8 cycles, 400 ns; four-cycle halves still clear the sampling lag
    task automatic bit_io(input logic b, output logic r);
        wait_clk(1);
        sda_pull = !b;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(2);
        r = sda;
        wait_clk(2);
        scl = 1'b0;
    endtask : bit_io

    // Works from idle and, as a repeated start, from SCL low
    task automatic start_cond();
        wait_clk(1);
        sda_pull = 1'b0;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(3);
        sda_pull = 1'b1;
        wait_clk(3);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(1);
        sda_pull = 1'b1;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(3);
        sda_pull = 1'b0;
        wait_clk(4);
    endtask : stop_cond

    // Eight bits MSB first, then the ninth slot; ack_in high releases SDA
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_in, ack);
    endtask : byte_io
endmodule : i2c_bus_master

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
    import synth_i2c_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic sel = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [7:0] status = 8'h00;
    logic sda_out, sda_oe, ext_en, scl, sda_pull, sda_wire;
    logic [71:0] cfg;
    logic [71:0] exp = 72'h0;
    logic [9:0] dac;
    logic [31:0] seed = 32'h8b376937;
    logic [6:0] dev;
    logic oe_q = 1'b0;
    logic scl_q = 1'b1;
    line_s line_in;
    int n_errors = 0;
    int checks_done = 0;

    always #25 sys_clk = ~sys_clk;

    // Open-drain wire with pull-up; the device never owns SCL
    assign sda_wire = !(sda_pull || (sda_oe && !sda_out));
    assign line_in = '{scl: scl, sda: sda_wire};

    synth_i2c_slave_port u_synth_i2c_slave_port (
        .SYS_CLK(sys_clk),
        .RST(rst),
        .CE(ce),
        .LINE_IN(line_in),
        .SERIAL_PORT_SELECT_PIN(sel),
        .ADDR_STRAP(strap),
        .SDA_OUT(sda_out),
        .SDA_OE(sda_oe),
        .STATUS_BYTE(status),
        .CONFIG_WORD(cfg),
        .EXT_OSC_BUF_EN(ext_en),
        .DAC_CODE(dac)
    );

    i2c_bus_master u_i2c_bus_master (
        .clk(sys_clk),
        .sda(sda_wire),
        .scl(scl),
        .sda_pull(sda_pull)
    );

    function automatic logic [7:0] rnd8();
        seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
        return seed[7:0];
    endfunction : rnd8

    // Lowest bit of the byte lane a sub-address loads
    function automatic int lane_lsb(input logic [7:0] s);
        if (s < 8'h06)
            return 40 - 8 * s;
        return 64 - 8 * (s - 6);
    endfunction : lane_lsb

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic check(input logic [71:0] got, input logic [71:0] want);
        checks_done++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Write n bytes from sub; forced[8] fixes the first byte's value
    task automatic write_regs(input logic [6:0] a, input logic [7:0] sub, input int n, input logic ok,
                              input logic [8:0] forced);
        logic [7:0] r, d, s;
        logic k;
        s = sub;
        u_i2c_bus_master.start_cond();
        u_i2c_bus_master.byte_io({a, 1'b0}, 1'b1, r, k);
        check(k, !ok);
        u_i2c_bus_master.byte_io(sub, 1'b1, r, k);
        check(k, !ok);
        for (int i = 0; i < n; i++) begin
            d = (i == 0 && forced[8]) ? forced[7:0] : rnd8();
            u_i2c_bus_master.byte_io(d, 1'b1, r, k);
            check(k, !ok);
            if (ok && s <= 8'h08)
                exp[lane_lsb(s) +: 8] = d;
            s = s + 8'h01;
        end
        u_i2c_bus_master.stop_cond();
        check(cfg, exp);
        check(sda_oe, 1'b0);
    endtask : write_regs

    // Device may only move SDA while SCL is low
    always @(posedge sys_clk) begin
        if (!rst && scl && scl_q && sda_oe !== oe_q)
            check(sda_oe, oe_q);
        oe_q <= sda_oe;
        scl_q <= scl;
    end

    // Cycle limit against a hang
    initial begin
        for (int i = 0; i < 100000; i++)
            @(posedge sys_clk);
        n_errors++;
        $display("Error at %0t: cycle limit got %h expected %h", $time, 1'b1, 1'b0);
        final_report();
    end

    initial begin
        logic [7:0] r, m;
        logic k;
        m = rnd8();
        strap = m[2:0];
        dev = {4'hd, strap};
        tick(2);
        rst = 1'b0;
        tick(10);
        check(cfg, 72'h0);
        check(72'({ext_en, dac, sda_oe}), 72'h0);
        $display("test reset done");
        // Every register once, then the DAC code built from two of them
        for (int s = 0; s < 9; s++)
            write_regs(dev, s[7:0], 1, 1'b1, 9'h0);
        check(dac, {exp[71:64], exp[63:62]});
        write_regs(dev, 8'h01, 4, 1'b1, 9'h0);
        write_regs(dev, 8'h07, 4, 1'b1, 9'h0);
        $display("test write done");
        // All 32 functional modes
        for (int md = 0; md < 32; md++) begin
            m = rnd8();
            write_regs(dev, 8'h00, 1, 1'b1, {1'b1, m[7:6], md[4:0], m[0]});
            check(ext_en, md == 3 || md == 6 || md == 7);
        end
        $display("test mode done");
        // Current byte read, master ends with no ack and STOP
        for (int i = 0; i < 3; i++) begin
            status = rnd8();
            u_i2c_bus_master.start_cond();
            u_i2c_bus_master.byte_io({dev, 1'b1}, 1'b1, r, k);
            check(k, 1'b0);
            // First pass: a master acknowledge gets the same byte again
            if (i == 0) begin
                u_i2c_bus_master.byte_io(8'hff, 1'b0, r, k);
                check(r, status);
            end
            u_i2c_bus_master.byte_io(8'hff, 1'b1, r, k);
            check(r, status);
            u_i2c_bus_master.stop_cond();
            check(sda_oe, 1'b0);
        end
        $display("test read done");
        // Each single address bit wrong: no ack, nothing stored
        for (int b = 0; b < 7; b++)
            write_regs(dev ^ (7'h01 << b), 8'h00, 2, 1'b0, 9'h0);
        $display("test mismatch done");
        // Repeated START inside a data byte drops the partial byte
        u_i2c_bus_master.start_cond();
        u_i2c_bus_master.byte_io({dev, 1'b0}, 1'b1, r, k);
        u_i2c_bus_master.byte_io(8'h02, 1'b1, r, k);
        for (int i = 0; i < 4; i++)
            u_i2c_bus_master.bit_io(~exp[lane_lsb(8'h02) + 7 - i], k);
        write_regs(dev, 8'h03, 1, 1'b1, 9'h0);
        $display("test abort done");
        // Port deselected by strap: silent
        sel = 1'b1;
        tick(10);
        write_regs(dev, 8'h00, 1, 1'b0, 9'h0);
        sel = 1'b0;
        tick(10);
        write_regs(dev, 8'h05, 1, 1'b1, 9'h0);
        $display("test select done");
        // Clock enable low: port frozen, nothing answered or stored
        ce = 1'b0;
        write_regs(dev, 8'h00, 1, 1'b0, 9'h0);
        ce = 1'b1;
        tick(10);
        write_regs(dev, 8'h04, 1, 1'b1, 9'h0);
        $display("test enable done");
        final_report();
    end
endmodule : tb

`default_nettype wire
